/* File: core/pin_sync.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-stage synchroniser with edge pulses
// ----------------------------------------------------------------
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // Raw pins
    input  wire logic [WIDTH-1:0] raw,
    // Synchronised level and edges
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] meta_reg;  // First stage, read only by second
    logic [WIDTH-1:0] sync_reg;  // Second stage
    logic [WIDTH-1:0] prev_reg;  // Previous level for edges

    // Stages shift on each clock
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end
        else
        begin
            meta_reg <= raw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;
    assign fall  = ~sync_reg & prev_reg;
endmodule

/* File: core/quarter_div.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Clock divider giving a square wave and edge enables
// ----------------------------------------------------------------
module quarter_div
    import serial_port_pkg::*;
#(
    parameter int HALF = TX_CLK_HALF
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Divided clock level and edge enables
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic [3:0] cnt_reg;    // Cycles within one level
    logic [3:0] cnt_next;
    logic       lvl_reg;    // Divided clock level
    logic       lvl_next;
    logic       wrap;       // Level ends this cycle

    // Next count and level
    always_comb
    begin
        wrap     = (cnt_reg == 4'(HALF - 1));
        cnt_next = wrap ? 4'h0 : cnt_reg + 4'h1;
        lvl_next = wrap ? ~lvl_reg : lvl_reg;
    end

    // Register count and level
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cnt_reg <= 4'h0;
            lvl_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            lvl_reg <= lvl_next;
        end
    end

    assign level = lvl_reg;
    assign rise  = wrap & ~lvl_reg;
    assign fall  = wrap & lvl_reg;
endmodule

/* File: core/serial_port.sv */
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// Behaviour
// - Outside receive clock shifts received bits
// - Unused port: receive clock level readable
// - Clock source 0: transmit clock is input
// - Clock source 1: drive quarter-rate transmit clock
// - Unused port: transmit clock level readable
// - Transmit shift register drives serial output
// - Serial output floats when not transmitting
// - Receive frame sync fall starts receiving
// - TDM mode: receive sync pin carries address
// - Transmit frame sync fall starts transmitting
// - Transmit sync input until direction bit or TDM mode set
// - TDM mode: transmit sync is frame pulse
// - Float condition tri-states every output
module serial_port
    import serial_port_pkg::*;
#(
    parameter int WORD = 16,  // Bits per serial word
    parameter int ADRW = 8    // TDM address bits
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Receive pins
    input  wire logic        rx_serial_clock,
    input  wire logic        serial_in_pin,
    input  wire logic        rx_frame_sync_i,
    output logic             rx_frame_sync_o,
    output logic             rx_frame_sync_oe,
    // Transmit pins
    input  wire logic        tx_serial_clock_i,
    output logic             tx_serial_clock_o,
    output logic             tx_serial_clock_oe,
    output logic             serial_out_pin_o,
    output logic             serial_out_pin_oe,
    input  wire logic        tx_frame_sync_i,
    output logic             tx_frame_sync_o,
    output logic             tx_frame_sync_oe,
    // Test and emulation pins
    input  wire logic        test_reset_n,
    input  wire logic        emulation_pin_a,
    input  wire logic        emulation_pin_b_float
);

    // ------------------------------------------------------------
    // Pin synchronisation and clock divider
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] raw;      // Pins from outside
    logic [PIN_COUNT-1:0] lvl;      // Synchronised levels
    logic [PIN_COUNT-1:0] rise;     // Rising edges
    logic [PIN_COUNT-1:0] fall;     // Falling edges
    logic                 div_lvl;  // Inside transmit clock
    logic                 div_rise;
    logic                 div_fall;
    logic                 float_on; // Float condition active

    // Float is test reset low, pin a high, pin b low
    assign raw = {~test_reset_n & emulation_pin_a & ~emulation_pin_b_float,
                  tx_frame_sync_i, rx_frame_sync_i, serial_in_pin,
                  tx_serial_clock_i, rx_serial_clock};

    pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .raw   (raw),
        .level (lvl),
        .rise  (rise),
        .fall  (fall)
    );

    quarter_div #(.HALF(TX_CLK_HALF)) u_div (
        .mclk  (mclk),
        .rst_n (rst_n),
        .level (div_lvl),
        .rise  (div_rise),
        .fall  (div_fall)
    );

    assign float_on = lvl[PIN_FLOAT];

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    ctrl_s             ctrl_reg, ctrl_next;       // Control bits
    logic [WORD-1:0]   tx_data_reg, tx_data_next; // Word to send
    logic              tx_pend_reg, tx_pend_next; // Word waiting
    logic [WORD-1:0]   rx_data_reg, rx_data_next; // Last word received
    logic              rx_full_reg, rx_full_next; // Word waiting
    logic [ADRW-1:0]   adr_reg, adr_next;         // TDM port address
    logic              wr_reg, wr_next;           // Write data phase
    logic [7:0]        wadr_reg, wadr_next;       // Write address
    logic [31:0]       rdata_reg, rdata_next;     // Read data
    logic              rx_smp_reg, rx_smp_next;   // Receive clock sample
    logic              tx_smp_reg, tx_smp_next;   // Transmit clock sample
    logic              take;                      // Address phase taken
    logic              rx_done;                   // Word completed
    logic              tx_load;                   // Transmit word taken
    logic              tx_busy_reg;

    // ------------------------------------------------------------
    // Bus slave and registers
    // ------------------------------------------------------------
    // Decode, write, read and flag updates
    always_comb
    begin
        take         = hsel & htrans[1] & hready;
        wr_next      = take & hwrite;
        wadr_next    = haddr[7:0];
        ctrl_next    = ctrl_reg;
        tx_data_next = tx_data_reg;
        adr_next     = adr_reg;
        rdata_next   = rdata_reg;
        rx_full_next = rx_full_reg;
        tx_pend_next = tx_pend_reg & ~tx_load;
        // Sample bits only follow the pins while the port is unused
        rx_smp_next  = ctrl_reg.port_en ? 1'b0 : lvl[PIN_RX_CLK];
        tx_smp_next  = ctrl_reg.port_en ? 1'b0 : lvl[PIN_TX_CLK];
        // Write data phase
        if (wr_reg)
        begin
            case (wadr_reg)
                OFS_CTRL:    ctrl_next = ctrl_s'(hwdata[3:0]);
                OFS_TX_DATA:
                begin
                    tx_data_next = hwdata[WORD-1:0];
                    tx_pend_next = 1'b1;
                end
                OFS_TDM_ADR: adr_next = hwdata[ADRW-1:0];
                default:     ;
            endcase
        end
        // Read address phase, data stands in the next cycle
        if (take & ~hwrite)
        begin
            rdata_next = 32'h0;
            case (haddr[7:0])
                OFS_CTRL:
                begin
                    rdata_next[3:0]          = ctrl_reg;
                    rdata_next[BIT_RX_SMP]   = rx_smp_reg;
                    rdata_next[BIT_TX_SMP]   = tx_smp_reg;
                    rdata_next[BIT_TX_BUSY]  = tx_busy_reg;
                    rdata_next[BIT_TX_PEND]  = tx_pend_reg;
                    rdata_next[BIT_RX_FULL]  = rx_full_reg;
                end
                OFS_TX_DATA: rdata_next[WORD-1:0] = tx_data_reg;
                OFS_RX_DATA:
                begin
                    rdata_next[WORD-1:0] = rx_data_reg;
                    rx_full_next         = 1'b0;
                end
                OFS_TDM_ADR: rdata_next[ADRW-1:0] = adr_reg;
                default:     rdata_next = 32'h0;
            endcase
        end
        // A word finishing in the same cycle as the read keeps the flag
        if (rx_done)
        begin
            rx_full_next = 1'b1;
        end
    end

    // Register bus state
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl_reg    <= ctrl_s'(CTRL_RESET);
            tx_data_reg <= '0;
            tx_pend_reg <= 1'b0;
            rx_full_reg <= 1'b0;
            adr_reg     <= '0;
            wr_reg      <= 1'b0;
            wadr_reg    <= 8'h0;
            rdata_reg   <= 32'h0;
            rx_smp_reg  <= 1'b0;
            tx_smp_reg  <= 1'b0;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            tx_data_reg <= tx_data_next;
            tx_pend_reg <= tx_pend_next;
            rx_full_reg <= rx_full_next;
            adr_reg     <= adr_next;
            wr_reg      <= wr_next;
            wadr_reg    <= wadr_next;
            rdata_reg   <= rdata_next;
            rx_smp_reg  <= rx_smp_next;
            tx_smp_reg  <= tx_smp_next;
        end
    end

    assign hrdata    = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic [WORD-1:0] rx_shift_reg, rx_shift_next; // Incoming bits
    logic [4:0]      rx_cnt_reg, rx_cnt_next;     // Bits taken
    logic            rx_busy_reg, rx_busy_next;   // Receive in progress
    logic            rx_start;

    // Start on frame sync fall, sample on each clock fall
    always_comb
    begin
        rx_start      = ctrl_reg.port_en & ~rx_busy_reg & fall[PIN_RX_FS];
        rx_shift_next = rx_shift_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_busy_next  = rx_busy_reg;
        rx_data_next  = rx_data_reg;
        rx_done       = 1'b0;
        if (rx_start)
        begin
            rx_busy_next = 1'b1;
            rx_cnt_next  = 5'h0;
        end
        else if (rx_busy_reg & fall[PIN_RX_CLK])
        begin
            // One bit per edge, first bit ends up highest
            rx_shift_next = {rx_shift_reg[WORD-2:0], lvl[PIN_DIN]};
            rx_cnt_next   = rx_cnt_reg + 5'h1;
            if (rx_cnt_reg == 5'(WORD - 1))
            begin
                rx_busy_next = 1'b0;
                rx_data_next = {rx_shift_reg[WORD-2:0], lvl[PIN_DIN]};
                rx_done      = 1'b1;
            end
        end
    end

    // Register receive state
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rx_shift_reg <= '0;
            rx_cnt_reg   <= 5'h0;
            rx_busy_reg  <= 1'b0;
            rx_data_reg  <= '0;
        end
        else
        begin
            rx_shift_reg <= rx_shift_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_busy_reg  <= rx_busy_next;
            rx_data_reg  <= rx_data_next;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    logic [WORD-1:0] tx_shift_reg, tx_shift_next; // Outgoing bits
    logic [4:0]      tx_cnt_reg, tx_cnt_next;     // Bits sent
    logic            tx_busy_next;
    logic            fs_drv_reg, fs_drv_next;     // Driven frame sync level
    logic            fs_out_en;                   // Frame sync is output
    logic            tx_rise;                     // Active transmit clock edge
    logic            tx_start;

    // Start on frame sync fall, or on a clock rise when driving own sync; shift on each clock rise
    always_comb
    begin
        fs_out_en     = ctrl_reg.frame_sync_dir | ctrl_reg.tdm_mode;
        tx_rise       = ctrl_reg.clock_source ? div_rise : rise[PIN_TX_CLK];
        fs_drv_next   = fs_drv_reg;
        tx_shift_next = tx_shift_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_busy_next  = tx_busy_reg;
        tx_load       = 1'b0;
        // Own frame pulse: low for one clock period, alongside the first bit of the word
        if (fs_out_en)
        begin
            tx_start = ctrl_reg.port_en & ~tx_busy_reg & tx_pend_reg & tx_rise & fs_drv_reg;
            if (tx_start)
            begin
                fs_drv_next = 1'b0;
            end
            else if (tx_rise)
            begin
                fs_drv_next = 1'b1;
            end
        end
        else
        begin
            fs_drv_next = 1'b1;
            tx_start    = ctrl_reg.port_en & ~tx_busy_reg & tx_pend_reg & fall[PIN_TX_FS];
        end
        if (tx_start)
        begin
            tx_busy_next  = 1'b1;
            tx_load       = 1'b1;
            tx_shift_next = tx_data_reg;
            tx_cnt_next   = 5'h0;
        end
        else if (tx_busy_reg & tx_rise)
        begin
            // Highest bit first, one bit per edge
            tx_shift_next = {tx_shift_reg[WORD-2:0], 1'b0};
            tx_cnt_next   = tx_cnt_reg + 5'h1;
            if (tx_cnt_reg == 5'(WORD - 1))
            begin
                tx_busy_next = 1'b0;
            end
        end
    end

    // Register transmit state
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            tx_shift_reg <= '0;
            tx_cnt_reg   <= 5'h0;
            tx_busy_reg  <= 1'b0;
            fs_drv_reg   <= 1'b1;
        end
        else
        begin
            tx_shift_reg <= tx_shift_next;
            tx_cnt_reg   <= tx_cnt_next;
            tx_busy_reg  <= tx_busy_next;
            fs_drv_reg   <= fs_drv_next;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    pin_drive_s txc_reg, txc_next; // Transmit clock
    pin_drive_s dout_reg, dout_next; // Serial output
    pin_drive_s fsx_reg, fsx_next; // Transmit frame sync
    pin_drive_s fsr_reg, fsr_next; // Receive sync or TDM address

    // Drive levels and enables, all released while floating
    always_comb
    begin
        txc_next.o   = div_lvl;
        txc_next.oe  = ctrl_reg.clock_source & ~float_on;
        dout_next.o  = tx_shift_next[WORD-1];
        dout_next.oe = tx_busy_next & ~float_on;
        fsx_next.o   = fs_drv_next;
        fsx_next.oe  = fs_out_en & ~float_on;
        // Address bits go out alongside the first data bits
        fsr_next.o   = (tx_cnt_next < 5'(ADRW)) ? adr_reg[tx_cnt_next[$clog2(ADRW)-1:0]] : 1'b0;
        fsr_next.oe  = ctrl_reg.tdm_mode & tx_busy_next & ~float_on;
        if (float_on)
        begin
            txc_next.oe  = 1'b0;
            dout_next.oe = 1'b0;
        end
    end

    // Register pin drivers
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            txc_reg  <= '0;
            dout_reg <= '0;
            fsx_reg  <= '{o: 1'b1, oe: 1'b0};
            fsr_reg  <= '0;
        end
        else
        begin
            txc_reg  <= txc_next;
            dout_reg <= dout_next;
            fsx_reg  <= fsx_next;
            fsr_reg  <= fsr_next;
        end
    end

    assign tx_serial_clock_o  = txc_reg.o;
    assign tx_serial_clock_oe = txc_reg.oe;
    assign serial_out_pin_o   = dout_reg.o;
    assign serial_out_pin_oe  = dout_reg.oe;
    assign tx_frame_sync_o    = fsx_reg.o;
    assign tx_frame_sync_oe   = fsx_reg.oe;
    assign rx_frame_sync_o    = fsr_reg.o;
    assign rx_frame_sync_oe   = fsr_reg.oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_float_all_off: assert property ($past(float_on) |-> !(tx_serial_clock_oe | serial_out_pin_oe |
        tx_frame_sync_oe | rx_frame_sync_oe)) else $error("Output driven while floating");
    chk_dout_idle_z: assert property (serial_out_pin_oe |-> tx_busy_reg)
        else $error("Serial output driven while idle");
    chk_txclk_input: assert property (!ctrl_reg.clock_source |=> !tx_serial_clock_oe)
        else $error("Transmit clock driven with clock source clear");
    chk_txclk_quarter: assert property ($rose(tx_serial_clock_o) |=>
        (!$rose(tx_serial_clock_o))[*3] ##1 $rose(tx_serial_clock_o)) else $error("Transmit clock not quarter rate");
    chk_fsx_input: assert property (!ctrl_reg.frame_sync_dir && !ctrl_reg.tdm_mode |=> !tx_frame_sync_oe)
        else $error("Transmit frame sync driven as input");
    chk_addr_pin_dir: assert property (!ctrl_reg.tdm_mode |=> !rx_frame_sync_oe)
        else $error("Address pin driven outside TDM mode");
    chk_rx_start: assert property (rx_start |=> rx_busy_reg && rx_cnt_reg == 5'h0)
        else $error("Receive did not start on frame sync");
    chk_rx_word_end: assert property (rx_busy_reg && fall[PIN_RX_CLK] && rx_cnt_reg == 5'(WORD - 1)
        |=> !rx_busy_reg && rx_full_reg) else $error("Receive word not completed");
    // A new word written in the start cycle keeps the pending flag set
    chk_tx_start: assert property (tx_start |=> tx_busy_reg && serial_out_pin_oe == !$past(float_on) &&
        (!tx_pend_reg || $past(wr_reg && wadr_reg == OFS_TX_DATA)))
        else $error("Transmit did not start on frame sync");
    chk_sample_rx: assert property (!ctrl_reg.port_en |=> rx_smp_reg == $past(lvl[PIN_RX_CLK]))
        else $error("Receive clock sample wrong");
    chk_sample_tx: assert property (!ctrl_reg.port_en |=> tx_smp_reg == $past(lvl[PIN_TX_CLK]))
        else $error("Transmit clock sample wrong");

    cov_rx_word: cover property (rx_done);
    cov_tx_word: cover property ($fell(tx_busy_reg));
    cov_own_fs: cover property (tx_start && fs_out_en);
    cov_float: cover property ($rose(float_on));

endmodule

/* File: inc/serial_port_pkg.sv */
package serial_port_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00; // Control and sample bits
    localparam logic [7:0] OFS_TX_DATA = 8'h04; // Transmit word
    localparam logic [7:0] OFS_RX_DATA = 8'h08; // Received word
    localparam logic [7:0] OFS_TDM_ADR = 8'h0c; // Port address for TDM mode

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int BIT_PORT_EN  = 0; // Serial port in use
    localparam int BIT_CLK_SRC  = 1; // Transmit clock made inside
    localparam int BIT_FS_DIR   = 2; // Transmit frame sync driven
    localparam int BIT_TDM_MODE = 3; // Time-division mode
    localparam int BIT_RX_SMP   = 4; // Receive clock pin level
    localparam int BIT_TX_SMP   = 5; // Transmit clock pin level
    localparam int BIT_TX_BUSY  = 6; // Transmission in progress
    localparam int BIT_TX_PEND  = 7; // Transmit word waiting
    localparam int BIT_RX_FULL  = 8; // Received word waiting

    localparam logic [3:0] CTRL_RESET = 4'h0; // All inputs after reset

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int MCLK_PERIOD_PS = 5000;   // 200 MHz clock
    localparam int TX_CLK_DIV     = 4;      // Quarter of master clock
    localparam int TX_CLK_HALF    = TX_CLK_DIV / 2; // Cycles per level
    localparam int SYNC_STAGES    = 2;      // Pin synchroniser depth

    // ------------------------------------------------------------
    // Pin input vector positions into the synchroniser
    // ------------------------------------------------------------
    localparam int PIN_RX_CLK = 0;
    localparam int PIN_TX_CLK = 1;
    localparam int PIN_DIN    = 2;
    localparam int PIN_RX_FS  = 3;
    localparam int PIN_TX_FS  = 4;
    localparam int PIN_FLOAT  = 5;
    localparam int PIN_COUNT  = 6;

    // Software control bits
    typedef struct packed {
        logic tdm_mode;        // Time-division mode
        logic frame_sync_dir;  // Transmit frame sync is output
        logic clock_source;    // Transmit clock made inside
        logic port_en;         // Serial port in use
    } ctrl_s;

    // Two-way pin drive
    typedef struct packed {
        logic o;   // Level driven
        logic oe;  // Drive enable, high while driving
    } pin_drive_s;

endpackage

/* File: tb/framed_serial_port_pins_tb_top.sv */
`timescale 1ns/1ps
module framed_serial_port_pins_tb_top;
    import serial_port_pkg::*;
    logic        mclk, rst_n, hsel, hwrite, trst_n, emu_a, emu_b;
    logic [31:0] haddr, hwdata, q;
    logic [1:0]  htrans;
    logic [15:0] x, y;
    logic [7:0]  a;
    wire  [31:0] hrdata;
    wire  [15:0] got;
    wire         hrdy, r_o, r_oe, c_o, c_oe, s_o, s_oe, f_o, f_oe, lclk, pfs, psd;
    int          err_total, num_checks, n;
    serial_port dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
        .hreadyout(hrdy), .hresp(), .rx_serial_clock(lclk), .serial_in_pin(psd),
        .rx_frame_sync_i(pfs), .rx_frame_sync_o(r_o), .rx_frame_sync_oe(r_oe),
        .tx_serial_clock_i(lclk), .tx_serial_clock_o(c_o), .tx_serial_clock_oe(c_oe),
        .serial_out_pin_o(s_o), .serial_out_pin_oe(s_oe), .tx_frame_sync_i(pfs),
        .tx_frame_sync_o(f_o), .tx_frame_sync_oe(f_oe), .test_reset_n(trst_n),
        .emulation_pin_a(emu_a), .emulation_pin_b_float(emu_b));
    // Released data line shows the inverse of the last level
    serial_peer peer (.lclk(lclk), .fs(pfs), .sd(psd), .dout(s_oe ? s_o : ~s_o), .got(got));
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // Verdict and end of run
    task final_report;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task ck(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    // Bounded wait for hready
    task wt;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (hrdy !== 1'b1 && n < 99);
        if (hrdy !== 1'b1)
        begin
            err_total++;
            final_report;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wt;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
        q = hrdata;
    endtask
    initial
    begin
        {rst_n, hsel, hwrite, emu_a, haddr, hwdata, htrans} = '0;
        {trst_n, emu_b} = 2'h3;
        err_total = 0;
        num_checks = 0;
        void'($urandom(42846));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        ck("fs_oe", 0, f_oe);
        ck("dout_oe", 0, s_oe);
        // Idle clock pin levels seen by software
        for (int v = 0; v < 2; v++)
        begin
            peer.lclk = v[0];
            repeat (4) @(posedge mclk);
            bus(1'b0, OFS_CTRL, 0);
            ck("smp", {v[0], v[0]}, q[5:4]);
        end
        // Corner then random words both ways
        for (int i = 0; i < 5; i++)
        begin
            x = (i == 0) ? 16'h8001 : (i == 1) ? 16'hfffe : 16'($urandom);
            y = (i == 0) ? 16'h7ffe : 16'($urandom);
            bus(1'b1, OFS_CTRL, 1);
            bus(1'b1, OFS_TX_DATA, {16'h0000, x});
            #1.25 peer.frame(y);
            repeat (8) @(posedge mclk);
            ck("dout_oe", 0, s_oe);
            ck("tx_word", x, got);
            bus(1'b0, OFS_RX_DATA, 0);
            ck("rx_word", y, q);
        end
        bus(1'b1, OFS_CTRL, 5);
        repeat (2) @(posedge mclk);
        ck("fs_oe", 1, f_oe);
        bus(1'b1, OFS_CTRL, 9);
        repeat (2) @(posedge mclk);
        ck("frm_oe", 1, f_oe);
        bus(1'b1, OFS_CTRL, 3);
        repeat (4) @(posedge mclk);
        ck("clk_oe", 1, c_oe);
        n = 0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge mclk);
            n += c_o;
        end
        ck("clk_hi", 4, n);
        // Own frame pulse and address bits in TDM mode on the inner clock
        x = 16'($urandom);
        a = 8'($urandom);
        bus(1'b1, OFS_TDM_ADR, {24'h000000, a});
        bus(1'b1, OFS_TX_DATA, {16'h0000, x});
        bus(1'b1, OFS_CTRL, 11);
        n = 0;
        while (f_o !== 1'b0 && n < 40)
        begin
            @(negedge mclk);
            n++;
        end
        ck("frm_low", 0, f_o);
        for (int k = 0; k < 16; k++)
        begin
            ck("tdm_dout", x[15-k], s_o);
            ck("tdm_adr", (k < 8) ? a[k] : 1'b0, r_o);
            ck("tdm_adr_oe", 1, r_oe);
            repeat (4) @(negedge mclk);
        end
        ck("frm_idle", 1, f_o);
        ck("tdm_dout_oe", 0, s_oe);
        @(posedge mclk);
        trst_n <= 1'b0;
        emu_a  <= 1'b1;
        emu_b  <= 1'b0;
        repeat (5) @(posedge mclk);
        ck("float", 0, {c_oe, f_oe, s_oe, r_oe});
        final_report;
    end
endmodule

/* File: tb/serial_peer.sv */
`timescale 1ns/1ps
// Far-side framed peer: link clock idles high, stands still between frames
module serial_peer (
    // Link pins
    output logic             lclk,
    output logic             fs,
    output logic             sd,
    input  wire logic        dout,
    // Word captured from the device
    output logic      [15:0] got
);
    initial
    begin
        lclk = 1'b1;
        fs   = 1'b1;
        sd   = 1'b0;
        got  = 16'h0000;
    end
    // One frame: sync fall, then 16 clock periods
    task automatic frame(input logic [15:0] w);
        fs = 1'b0;
        #64 fs = 1'b1;
        for (int i = 15; i >= 0; i--)
        begin
            sd = w[i];
            #32 lclk = 1'b0;
            got = {got[14:0], dout};
            #32 lclk = 1'b1;
        end
        sd = ~sd; // Released line shows no stale bit
    endtask
endmodule
